//--- hdl/htc_timer.v
// Behaviour
// - 16-bit up/down counter, compare, PWM
// - Watchdog, clear-on-match, fast PWM, phase-correct modes
// - Selectable clock source through programmable prescaler
// - Overflow, compare and capture interrupt events
// - Static interrupt plus separate wake-up interrupt
// - Rising capture edge copies count when enabled, except in PWM or standalone mode
// - Irq is overflow flag standalone, else registers
// - Standalone mode preloads reset-pin enable
// - Glitch-free PWM even when period changes
// - Registers reached by ordinary bus cycles
// - Compare/PWM waveform driven on output pin
`timescale 1ns/1ns
`default_nettype none
`include "htc_defines.vh"
module htc_timer (
    input wire aclk,
    input wire aresetn,
    input wire standalone_mode,
    input wire [7:0] preload_ctrl,
    input wire [15:0] preload_top,
    input wire [15:0] preload_cmp,
    input wire counter_clock_in,
    input wire counter_reset_n,
    input wire capture_trigger_in,
    output reg counter_irq_out,
    output reg wakeup_irq_out,
    output reg compare_wave_out,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    reg [7:0] ctrl_q;
    reg [15:0] top_q;
    reg [15:0] cmp_q;
    reg [15:0] pre_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_en_q;
    reg clk_sel_q;
    reg [15:0] current_count_value;
    reg [15:0] capture_value_reg;
    reg [15:0] top_act_q;
    reg [15:0] cmp_act_q;
    reg [15:0] pre_cnt_q;
    reg dir_down_q;
    reg ext_clk_prev_q;
    reg cap_prev_q;
    reg ovf_flag_q;
    reg [31:0] aw_addr_q;
    reg aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_have_q;
    wire ext_clk_s;
    wire cap_s;
    wire rst_req_s;

    // Map a byte address to a word index, or flag it unmapped
    function [4:0] htc_decode;
        input [31:0] addr;
        begin
            if (addr[31:`HTC_IDX_HI + 1] != 26'h0 || addr[`HTC_IDX_HI:`HTC_IDX_LO] > `HTC_OFF_SEL)
                htc_decode = 5'h10;
            else
                htc_decode = {1'b0, addr[`HTC_IDX_HI:`HTC_IDX_LO]};
        end
    endfunction

    // Pin inputs from outside the clock domain
    htc_sync3 u_clk_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(counter_clock_in),
        .dout(ext_clk_s)
    );
    htc_sync3 u_cap_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(capture_trigger_in),
        .dout(cap_s)
    );
    // Reset pin is asynchronous too; carried as a request so its idle level is low
    htc_sync3 u_rst_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(~counter_reset_n),
        .dout(rst_req_s)
    );

    // Edge and tick generation
    wire ext_rise = ext_clk_s & ~ext_clk_prev_q;
    wire src_tick = clk_sel_q ? ext_rise : 1'b1;
    wire pre_done = (pre_cnt_q == pre_q);
    wire tick = ctrl_q[`HTC_CTRL_EN] & src_tick & pre_done;
    wire [1:0] mode = ctrl_q[`HTC_CTRL_MODE_HI:`HTC_CTRL_MODE_LO];
    wire pwm_mode = mode[1];
    wire [15:0] wrap_top = (mode == `HTC_MODE_CTC) ? cmp_act_q : top_act_q;
    wire pin_reset = ctrl_q[`HTC_CTRL_RST_PIN_EN] & rst_req_s;
    wire cap_edge = cap_s & ~cap_prev_q;
    wire cap_ev = cap_edge & ctrl_q[`HTC_CTRL_CAP_EN] & ~pwm_mode & ~standalone_mode;
    wire down_cnt = ctrl_q[`HTC_CTRL_DOWN];
    wire at_top = down_cnt ? (current_count_value == `HTC_CNT_ZERO) :
        (current_count_value == wrap_top);
    wire ovf_ev = tick & (pwm_mode & mode[0] ? (dir_down_q &
        (current_count_value == `HTC_CNT_ONE)) : at_top);
    wire cmp_ev = tick & (current_count_value == cmp_act_q);

    // Counter, prescaler, double-buffered period and compare
    always @(posedge aclk) begin
        if (!aresetn || pin_reset) begin
            pre_cnt_q <= `HTC_PRE_RST;
            current_count_value <= `HTC_CNT_ZERO;
            dir_down_q <= 1'b0;
            ext_clk_prev_q <= 1'b0;
            top_act_q <= `HTC_TOP_RST;
            cmp_act_q <= `HTC_CMP_RST;
        end else begin
            ext_clk_prev_q <= ext_clk_s;
            if (src_tick) begin
                pre_cnt_q <= pre_done ? `HTC_PRE_RST : pre_cnt_q + `HTC_CNT_ONE;
            end
            if (tick) begin
                if (pwm_mode && mode[0]) begin
                    // Phase correct: count up to top then back to zero
                    if (!dir_down_q && current_count_value >= top_act_q) begin
                        dir_down_q <= 1'b1;
                        current_count_value <= current_count_value - `HTC_CNT_ONE;
                    end else if (dir_down_q && current_count_value == `HTC_CNT_ONE) begin
                        dir_down_q <= 1'b0;
                        current_count_value <= `HTC_CNT_ZERO;
                        top_act_q <= top_q;
                        cmp_act_q <= cmp_q;
                    end else if (dir_down_q) begin
                        current_count_value <= current_count_value - `HTC_CNT_ONE;
                    end else begin
                        current_count_value <= current_count_value + `HTC_CNT_ONE;
                    end
                end else if (at_top) begin
                    // Reload at the end of the period, never mid-period
                    current_count_value <= down_cnt ? wrap_top : `HTC_CNT_ZERO;
                    top_act_q <= top_q;
                    cmp_act_q <= cmp_q;
                end else begin
                    current_count_value <= down_cnt ? current_count_value - `HTC_CNT_ONE :
                        current_count_value + `HTC_CNT_ONE;
                end
            end
        end
    end

    // Waveform output, registered so it cannot glitch
    always @(posedge aclk) begin
        if (!aresetn || pin_reset) begin
            compare_wave_out <= 1'b0;
        end else begin
            case (mode)
                `HTC_MODE_FPWM: compare_wave_out <= ctrl_q[`HTC_CTRL_INV] ^
                    (current_count_value < cmp_act_q);
                `HTC_MODE_PFC: compare_wave_out <= ctrl_q[`HTC_CTRL_INV] ^
                    (current_count_value < cmp_act_q);
                `HTC_MODE_CTC: if (cmp_ev) begin
                    compare_wave_out <= ~compare_wave_out;
                end
                default: compare_wave_out <= compare_wave_out;
            endcase
        end
    end

    // Capture and overflow flag
    always @(posedge aclk) begin
        if (!aresetn) begin
            cap_prev_q <= 1'b0;
            capture_value_reg <= `HTC_CNT_ZERO;
            ovf_flag_q <= 1'b0;
        end else begin
            cap_prev_q <= cap_s;
            if (cap_ev) begin
                capture_value_reg <= current_count_value;
            end
            if (ovf_ev) begin
                ovf_flag_q <= 1'b1;
            end else if (tick) begin
                ovf_flag_q <= 1'b0;
            end
        end
    end

    // Interrupt outputs; watchdog expiry also wakes the standby controller
    always @(posedge aclk) begin
        if (!aresetn) begin
            counter_irq_out <= 1'b0;
            wakeup_irq_out <= 1'b0;
        end else begin
            counter_irq_out <= standalone_mode ? ovf_flag_q :
                |(irq_stat_q & irq_en_q);
            wakeup_irq_out <= |(irq_stat_q & irq_en_q) |
                (ovf_flag_q & (mode == `HTC_MODE_WDT));
        end
    end

    // AXI4-Lite write side: address and data in either order
    wire w_go = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
    wire [4:0] w_idx = htc_decode(aw_addr_q);
    wire wr_stat = w_go & (w_idx == {1'b0, `HTC_OFF_IRQ_STAT}) & w_strb_q[0];

    // Register file; stand-alone preload replaces bus writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 32'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HTC_RESP_OKAY;
            ctrl_q <= `HTC_CTRL_RST;
            top_q <= `HTC_TOP_RST;
            cmp_q <= `HTC_CMP_RST;
            pre_q <= `HTC_PRE_RST;
            irq_en_q <= 3'h0;
            clk_sel_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (standalone_mode) begin
                ctrl_q <= preload_ctrl | `HTC_CTRL_RST;
                top_q <= preload_top;
                cmp_q <= preload_cmp;
            end
            if (w_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_idx[4] ? `HTC_RESP_SLVERR : `HTC_RESP_OKAY;
                if (!standalone_mode) begin
                    // Unmapped places fold to an unused index, so nothing is written
                    case (w_idx[3:0] | {4{w_idx[4]}})
                        `HTC_OFF_CTRL: if (w_strb_q[0]) ctrl_q <= w_data_q[7:0];
                        `HTC_OFF_TOP: top_q <= {w_strb_q[1] ? w_data_q[15:8] : top_q[15:8],
                            w_strb_q[0] ? w_data_q[7:0] : top_q[7:0]};
                        `HTC_OFF_CMP: cmp_q <= {w_strb_q[1] ? w_data_q[15:8] : cmp_q[15:8],
                            w_strb_q[0] ? w_data_q[7:0] : cmp_q[7:0]};
                        `HTC_OFF_PRE: pre_q <= {w_strb_q[1] ? w_data_q[15:8] : pre_q[15:8],
                            w_strb_q[0] ? w_data_q[7:0] : pre_q[7:0]};
                        `HTC_OFF_IRQ_EN: if (w_strb_q[0]) irq_en_q <= w_data_q[2:0];
                        `HTC_OFF_SEL: if (w_strb_q[0]) clk_sel_q <= w_data_q[0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    wire [2:0] ev_vec = {cap_ev, cmp_ev, ovf_ev};
    genvar gi;
    generate
        for (gi = 0; gi < `HTC_IRQ_W; gi = gi + 1) begin : g_irq
            always @(posedge aclk) begin
                if (!aresetn) begin
                    irq_stat_q[gi] <= 1'b0;
                end else if (ev_vec[gi]) begin
                    irq_stat_q[gi] <= 1'b1;
                end else if (wr_stat && w_data_q[gi]) begin
                    irq_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // AXI4-Lite read side, one cycle from address to data
    assign s_axi_arready = ~s_axi_rvalid;
    wire [4:0] r_idx = htc_decode(s_axi_araddr);
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `HTC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= r_idx[4] ? `HTC_RESP_SLVERR : `HTC_RESP_OKAY;
            // Unmapped places fold to an unused index and read as zero
            case (r_idx[3:0] | {4{r_idx[4]}})
                `HTC_OFF_CTRL: s_axi_rdata <= {24'h0, ctrl_q};
                `HTC_OFF_TOP: s_axi_rdata <= {16'h0, top_q};
                `HTC_OFF_CMP: s_axi_rdata <= {16'h0, cmp_q};
                `HTC_OFF_PRE: s_axi_rdata <= {16'h0, pre_q};
                `HTC_OFF_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_q};
                `HTC_OFF_IRQ_EN: s_axi_rdata <= {29'h0, irq_en_q};
                `HTC_OFF_CNT: s_axi_rdata <= {16'h0, current_count_value};
                `HTC_OFF_CAP: s_axi_rdata <= {16'h0, capture_value_reg};
                `HTC_OFF_SEL: s_axi_rdata <= {31'h0, clk_sel_q};
                default: s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // htc_timer
`default_nettype wire

//--- pkg/htc_defines.vh
`ifndef HTC_DEFINES_VH
`define HTC_DEFINES_VH
// Register word indices
`define HTC_OFF_CTRL 4'h0
`define HTC_OFF_TOP 4'h1
`define HTC_OFF_CMP 4'h2
`define HTC_OFF_PRE 4'h3
`define HTC_OFF_IRQ_STAT 4'h4
`define HTC_OFF_IRQ_EN 4'h5
`define HTC_OFF_CNT 4'h6
`define HTC_OFF_CAP 4'h7
`define HTC_OFF_SEL 4'h8
// Word index field of the byte address
`define HTC_IDX_HI 5
`define HTC_IDX_LO 2
// Control fields
`define HTC_CTRL_EN 0
`define HTC_CTRL_MODE_HI 2
`define HTC_CTRL_MODE_LO 1
`define HTC_CTRL_CAP_EN 3
`define HTC_CTRL_RST_PIN_EN 4
`define HTC_CTRL_DOWN 5
`define HTC_CTRL_INV 6
`define HTC_CTRL_RST 8'h10
// Modes
`define HTC_MODE_WDT 2'h0
`define HTC_MODE_CTC 2'h1
`define HTC_MODE_FPWM 2'h2
`define HTC_MODE_PFC 2'h3
// Interrupt bits
`define HTC_IRQ_OVF 0
`define HTC_IRQ_CMP 1
`define HTC_IRQ_CAP 2
`define HTC_IRQ_W 3
// Widths and reset values
`define HTC_CW 16
`define HTC_TOP_RST 16'hffff
`define HTC_CMP_RST 16'h8000
`define HTC_PRE_RST 16'h0000
`define HTC_CNT_ZERO 16'h0000
`define HTC_CNT_ONE 16'h0001
// AXI responses
`define HTC_RESP_OKAY 2'h0
`define HTC_RESP_SLVERR 2'h2
`endif

//--- hdl/htc_sync3.v
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser with agreement filter on the last two stages
module htc_sync3 (
    input wire aclk,
    input wire aresetn,
    input wire din,
    output reg dout
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // Only s2 reads s1; a change counts when s2 and s3 agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule // htc_sync3
`default_nettype wire

//--- tb/htc_timer_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "htc_defines.vh"
// Bus and interrupt relations seen at the timer's pins
module htc_timer_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic standalone_mode,
    input wire logic counter_irq_out,
    input wire logic wakeup_irq_out,
    input wire logic compare_wave_out,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Write cycle in two steps: both channels taken, then the answer
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_answer;
        ##[1:2] s_axi_bvalid;
    endsequence
    AST_B_AFTER_WRITE: assert property (wr_both |-> b_answer)
        else $error("write answer missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    AST_NO_AW_IN_B: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    AST_NO_AR_IN_R: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == `HTC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    AST_WAKE_FOLLOWS: assert property (!standalone_mode && !$past(standalone_mode) && counter_irq_out |-> wakeup_irq_out)
        else $error("wake-up missing with interrupt");
    AST_OUT_RESET: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !counter_irq_out && !compare_wave_out)
        else $error("outputs not idle after reset");
endmodule // htc_timer_properties
bind htc_timer htc_timer_properties htc_timer_properties_inst (.*);
`default_nettype wire

//--- tb/htc_axi_master.sv
`timescale 1ns/1ns
`default_nettype none
// Fabric user logic as bus master; one transfer at a time
module htc_axi_master (
    input wire logic aclk,
    output logic [31:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [31:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    output logic rready
);
    initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    // Address and data offered together, each dropped when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // Read data taken at the edge that ends the cycle
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule // htc_axi_master
`default_nettype wire

//--- tb/htc_timer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "htc_defines.vh"
module htc_timer_bench;
    localparam logic [1:0] ok_r = `HTC_RESP_OKAY;
    localparam logic [1:0] er_r = `HTC_RESP_SLVERR;
    localparam logic [31:0] ra [7] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h14, 32'h18, 32'h20};
    localparam logic [31:0] rr [7] = '{32'h10, 32'hffff, 32'h8000, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] pt [4] = '{32'h9, 32'h9, 32'h13, 32'h5};
    localparam logic [31:0] pc [4] = '{32'h15, 32'h55, 32'h15, 32'h17};
    localparam logic [31:0] ph [4] = '{32'd30, 32'd70, 32'd15, 32'd50};
    logic aclk = 1'b0, aresetn = 1'b0, standalone_mode = 1'b0;
    logic [7:0] preload_ctrl = 8'h00;
    logic [15:0] preload_top = 16'h0000, preload_cmp = 16'h0000;
    logic counter_clock_in = 1'b0, counter_reset_n = 1'b1, capture_trigger_in = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hf;
    wire logic counter_irq_out, wakeup_irq_out, compare_wave_out;
    wire logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int num_errors = 0, compares = 0;
    logic [65:0] exp_q [$];
    logic [65:0] ent;
    logic [31:0] rv, hi;
    htc_timer htc_timer_inst (.*);
    htc_axi_master htc_axi_master_inst (.aclk(aclk), .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid), .awready(s_axi_awready), .wdata(s_axi_wdata),
        .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bvalid(s_axi_bvalid),
        .bready(s_axi_bready), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
        .arready(s_axi_arready), .rdata(s_axi_rdata), .rvalid(s_axi_rvalid),
        .rready(s_axi_rready));
    initial forever #5 aclk = ~aclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            num_errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Note the expected answer first, then run the bus cycle
    task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] d,
        input logic [1:0] r);
        exp_q.push_back({r, m, d});
        htc_axi_master_inst.rd(a, rv);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({r, 32'h0, 32'h0});
        htc_axi_master_inst.wr(a, d);
    endtask
    // Oldest note against each answer as it is taken
    always @(posedge aclk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            ent = exp_q.pop_front();
            check({30'h0, s_axi_bvalid ? s_axi_bresp : s_axi_rresp}, {30'h0, ent[65:64]});
            if (s_axi_rvalid) check(s_axi_rdata & ent[63:32], ent[31:0]);
        end
    end
    // Counts wave-high cycles over whole periods
    task automatic count_high();
        hi = 32'h0;
        repeat (100) begin
            @(posedge aclk);
            hi = hi + {31'h0, compare_wave_out};
        end
    endtask
    initial begin
        rv = $urandom(32'h48ef09bf);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, then unmapped places
        for (int i = 0; i < 7; i++) rd(ra[i], 32'hffff, rr[i], ok_r);
        rd(32'h40, 32'hffffffff, 32'h0, er_r);
        wr(32'h44, $urandom, er_r);
        for (int i = 0; i < 4; i++) begin
            rv = $urandom;
            wr(32'h8, rv, ok_r);
            rd(32'h8, 32'hffff, rv & 32'hffff, ok_r);
        end
        // Fast PWM, inverted, period changed while running, then phase correct
        for (int i = 0; i < 4; i++) begin
            wr(32'h4, pt[i], ok_r);
            wr(32'h8, 32'h3, ok_r);
            wr(32'h0, pc[i], ok_r);
            repeat (i == 0 ? 66000 : 60) @(posedge aclk); // Old period may run out first
            count_high();
            check(hi, ph[i]);
        end
        // Overflow event raised, then masked
        wr(32'h14, 32'h1, ok_r);
        wr(32'h0, 32'h11, ok_r);
        repeat (40) @(posedge aclk);
        check({31'h0, counter_irq_out}, 32'h1);
        check({31'h0, wakeup_irq_out}, 32'h1);
        rd(32'h10, 32'h1, 32'h1, ok_r);
        wr(32'h14, 32'h0, ok_r);
        repeat (2) @(posedge aclk);
        check({31'h0, counter_irq_out}, 32'h0);
        // Clear-on-match wrap counting down, so no stale count runs past the match
        wr(32'h0, 32'h10, ok_r);
        wr(32'h10, 32'h7, ok_r);
        wr(32'h8, 32'h5, ok_r);
        wr(32'h14, 32'h4, ok_r);
        wr(32'h0, 32'h3b, ok_r);
        repeat (30) @(posedge aclk);
        check({31'h0, counter_irq_out}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            rd(32'h18, 32'h0, 32'h0, ok_r);
            check({31'h0, rv <= 32'h5}, 32'h1);
        end
        capture_trigger_in <= 1'b1;
        repeat (8) @(posedge aclk);
        capture_trigger_in <= 1'b0;
        repeat (8) @(posedge aclk);
        check({31'h0, counter_irq_out}, 32'h1);
        rd(32'h1c, 32'h0, 32'h0, ok_r);
        check({31'h0, rv <= 32'h5}, 32'h1);
        rd(32'h10, 32'h4, 32'h4, ok_r);
        // External clock pin: count frozen between edges, one step down per edge
        wr(32'h20, 32'h1, ok_r);
        rd(32'h18, 32'h0, 32'h0, ok_r);
        hi = rv;
        repeat (2) begin
            counter_clock_in <= 1'b1;
            repeat (6) @(posedge aclk);
            counter_clock_in <= 1'b0;
            repeat (6) @(posedge aclk);
        end
        rd(32'h18, 32'hffff, (hi + 32'h4) % 32'h6, ok_r);
        wr(32'h20, 32'h0, ok_r);
        // Stand-alone: interrupt is the overflow flag, reset pin honoured
        wr(32'h0, 32'h10, ok_r);
        wr(32'h10, 32'h7, ok_r);
        preload_ctrl <= 8'h01;
        preload_top <= 16'h000f;
        preload_cmp <= 16'h0008;
        standalone_mode <= 1'b1;
        repeat (60) @(posedge aclk);
        // One flag cycle per 16-cycle period
        hi = 32'h0;
        repeat (64) begin
            @(posedge aclk);
            hi = hi + {31'h0, counter_irq_out};
        end
        check(hi, 32'h4);
        counter_reset_n <= 1'b0;
        repeat (10) @(posedge aclk);
        rd(32'h18, 32'hffff, 32'h0, ok_r);
        check({31'h0, counter_irq_out}, 32'h0);
        counter_reset_n <= 1'b1;
        tally_and_finish();
    end
    // Hang guard well beyond the longest scenario
    initial begin
        repeat (90000) @(posedge aclk);
        num_errors++;
        tally_and_finish();
    end
endmodule // htc_timer_bench
`default_nettype wire
